// ---- design/adch_cfg.svh ----
// timing figures, frame layout and counts for the serial converter readout host
`ifndef ADCH_CFG_SVH
`define ADCH_CFG_SVH

// system clock period
`define ADCH_CLK_PS        4000
// fastest serial clock periods, higher and lower supply variant
`define ADCH_SCLK_HI_PS    156250
`define ADCH_SCLK_LO_PS    208334
// serial clock pulse width high and low
`define ADCH_T_CH_PS       83000
// select fall to first clock rise setup
`define ADCH_T_CSS_PS      45000
// minimum deselect time
`define ADCH_T_CSW_PS      100000
// minimum acquisition time after an aborted conversion
`define ADCH_T_ACQ_PS      625000
// power-up and wake-up wait
`define ADCH_T_WAKE_US     1400

// frame layout: position 15 is the level driven at select fall
`define ADCH_EDGES_SHORT   13
`define ADCH_EDGES_BYTES   16
`define ADCH_FRAME_W       16
`define ADCH_RES_W         10
`define ADCH_SUB_W         2
`define ADCH_RES_LSB       3
`define ADCH_SUB_LSB       1
`define ADCH_CNT_W         20
`define ADCH_EDGE_W        5

`endif

// ---- design/adch_pkg.sv ----
// types shared by the serial converter readout host
package adch_pkg;

    typedef enum logic [2:0] {
        ADCH_WAKE  = 3'b000,
        ADCH_IDLE  = 3'b001,
        ADCH_LOW   = 3'b010,
        ADCH_HIGH  = 3'b011,
        ADCH_DESEL = 3'b100,
        ADCH_OFF   = 3'b101
    } adch_state_e;

endpackage

// ---- design/adch_host.sv ----
// host controller that starts conversions and reads the serial result frame
`timescale 1ns/1ps
`include "adch_cfg.svh"

// Rules of the document for the converter link
// R01: lowering select freezes the sample and starts a conversion in the converter
// R02: converter output leaves high impedance and drives low when a sequence starts
// R03: converter output changes only after rising serial clock edges
// R04: result msb appears after third rising edge, then descending bits
// R05: frame is three leading zeros then twelve bits, fifteen edges to shift
// R06: extra rising edges with select low yield zeros, harmless
// R07: converter output floats whenever select is high
// R08: lower select with serial clock held low, only then clock
// R09: give at least thirteen clocks, raise select no earlier than thirteenth edge
// R10: keep select low until every wanted data bit is clocked out
// R11: hold select high for the minimum deselect time before restarting
// R12: after an aborted conversion wait the acquisition time before restarting
// R13: serial clock no faster than 6.4MHz or 4.8MHz by supply variant
// R14: no conversion for 1.4ms after power is first applied
// R15: after leaving shutdown wait the wake-up time before converting
// R16: converter reference is off while shutdown input is low
// R17: shutdown input low powers down, high returns to normal mode
// R18: byte master uses polarity 0 phase 0 and two single-byte reads
// R19: first byte holds three zeros and five msbs, second the rest
// R20: thirteen-clock transfer gives two zeros then ten result bits
// R21: data may be captured on either edge, after clock-to-output delay
// R22: result is straight unipolar binary, lsb is reference over 1024
// R23: count rising edges from select fall, clear count when select rises
module adch_host #(
    parameter bit LOW_SUPPLY = 1'b0,
    parameter int WAKE_CYC   = (`ADCH_T_WAKE_US * 1000000) / `ADCH_CLK_PS
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_i,
    input  wire logic                    start_i,
    input  wire logic                    long_frame_i,
    input  wire logic                    abort_i,
    input  wire logic                    power_down_i,
    input  wire logic                    dout_i,
    output logic                         sclk_o,
    output logic                         cs_n_o,
    output logic                         power_down_n_o,
    output logic                         ready_o,
    output logic                         done_o,
    output logic                         aborted_o,
    output logic [`ADCH_RES_W-1:0]       result_o,
    output logic [`ADCH_SUB_W-1:0]       sub_bits_o,
    output logic [`ADCH_FRAME_W-1:0]     frame_o
);

    // serial clock half period: the pulse width floor and half the fastest period
    localparam int SCLK_PS     = LOW_SUPPLY ? `ADCH_SCLK_LO_PS : `ADCH_SCLK_HI_PS;
    localparam int PER_CYC     = (SCLK_PS + `ADCH_CLK_PS - 1) / `ADCH_CLK_PS;
    localparam int HALF_PER    = (PER_CYC + 1) / 2;
    localparam int HALF_CH     = (`ADCH_T_CH_PS + `ADCH_CLK_PS - 1) / `ADCH_CLK_PS;
    localparam int HALF_CYC    = (HALF_PER > HALF_CH) ? HALF_PER : HALF_CH;
    localparam int CSS_CYC     = (`ADCH_T_CSS_PS + `ADCH_CLK_PS - 1) / `ADCH_CLK_PS;
    localparam int SETUP_CYC   = (CSS_CYC > HALF_CYC) ? CSS_CYC : HALF_CYC;
    localparam int CSW_CYC     = (`ADCH_T_CSW_PS + `ADCH_CLK_PS - 1) / `ADCH_CLK_PS;
    localparam int ACQ_CYC     = (`ADCH_T_ACQ_PS + `ADCH_CLK_PS - 1) / `ADCH_CLK_PS;

    localparam logic [`ADCH_CNT_W-1:0] HALF_LD  = `ADCH_CNT_W'(HALF_CYC - 1);
    localparam logic [`ADCH_CNT_W-1:0] SETUP_LD = `ADCH_CNT_W'(SETUP_CYC - 1);
    localparam logic [`ADCH_CNT_W-1:0] CSW_LD   = `ADCH_CNT_W'(CSW_CYC - 1);
    localparam logic [`ADCH_CNT_W-1:0] ACQ_LD   = `ADCH_CNT_W'(ACQ_CYC - 1);
    localparam logic [`ADCH_CNT_W-1:0] WAKE_LD  = `ADCH_CNT_W'(WAKE_CYC - 1);

    localparam logic [`ADCH_EDGE_W-1:0] EDGES_SHORT = `ADCH_EDGE_W'(`ADCH_EDGES_SHORT);
    localparam logic [`ADCH_EDGE_W-1:0] EDGES_BYTES = `ADCH_EDGE_W'(`ADCH_EDGES_BYTES);
    localparam logic [`ADCH_EDGE_W-1:0] FRAME_LAST  = `ADCH_EDGE_W'(`ADCH_FRAME_W - 1);

    // state
    adch_pkg::adch_state_e state_q;
    adch_pkg::adch_state_e state_d;

    logic [`ADCH_CNT_W-1:0]   cnt_q;
    logic [`ADCH_CNT_W-1:0]   cnt_d;
    logic [`ADCH_EDGE_W-1:0]  edge_q;
    logic [`ADCH_EDGE_W-1:0]  edge_d;
    logic [`ADCH_EDGE_W-1:0]  target_q;
    logic [`ADCH_EDGE_W-1:0]  target_d;
    logic [`ADCH_FRAME_W-1:0] frame_q;
    logic [`ADCH_FRAME_W-1:0] frame_d;
    logic                     sclk_q;
    logic                     sclk_d;
    logic                     cs_n_q;
    logic                     cs_n_d;
    logic                     pwr_n_q;
    logic                     pwr_n_d;
    logic                     ready_q;
    logic                     done_q;
    logic                     done_d;
    logic                     aborted_q;
    logic                     aborted_d;
    logic [`ADCH_RES_W-1:0]   result_q;
    logic [`ADCH_SUB_W-1:0]   sub_q;
    logic [`ADCH_FRAME_W-1:0] frame_out_q;

    // data pin synchroniser
    logic                     dout_meta_q;
    logic                     dout_sync_q;

    // phase and decision terms
    wire cnt_zero     = (cnt_q == '0);
    wire in_frame     = (state_q == adch_pkg::ADCH_LOW) || (state_q == adch_pkg::ADCH_HIGH);
    wire low_end      = (state_q == adch_pkg::ADCH_LOW) && cnt_zero;
    wire high_end     = (state_q == adch_pkg::ADCH_HIGH) && cnt_zero;
    wire last_edge    = (edge_q == target_q);
    // a frame stopped before the thirteenth edge has not finished converting
    wire conv_done    = (edge_q >= EDGES_SHORT);
    wire abort_now    = abort_i && in_frame;
    wire start_ok     = start_i && (state_q == adch_pkg::ADCH_IDLE) && !power_down_i;

    // one-hot write of the captured level into its frame position
    wire                     pos_ok  = (edge_q <= FRAME_LAST);
    wire [3:0]               pos_idx = 4'(FRAME_LAST - edge_q);
    wire [`ADCH_FRAME_W-1:0] frame_cap;

    // each frame bit takes the pin level only at its own position, others keep
    genvar gi;
    generate
        for (gi = 0; gi < `ADCH_FRAME_W; gi++) begin : g_cap
            assign frame_cap[gi] = (pos_ok && (pos_idx == 4'(gi))) ? dout_sync_q : frame_q[gi];
        end
    endgenerate

    // next-state logic
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_zero ? cnt_q : cnt_q - `ADCH_CNT_W'(1);
        edge_d    = edge_q;
        target_d  = target_q;
        frame_d   = frame_q;
        sclk_d    = sclk_q;
        cs_n_d    = cs_n_q;
        pwr_n_d   = pwr_n_q;
        done_d    = 1'b0;
        aborted_d = 1'b0;
        case (state_q)
            adch_pkg::ADCH_WAKE: begin
                // reference settling after power-up or shutdown exit
                if (cnt_zero) begin // see R14 see R15
                    state_d = adch_pkg::ADCH_IDLE;
                end
            end
            adch_pkg::ADCH_IDLE: begin
                if (power_down_i) begin
                    state_d = adch_pkg::ADCH_OFF;
                    pwr_n_d = 1'b0; // see R16 see R17
                end else if (start_ok) begin
                    // select falls while the serial clock rests low
                    state_d  = adch_pkg::ADCH_LOW;
                    cs_n_d   = 1'b0; // see R01 see R08
                    sclk_d   = 1'b0;
                    cnt_d    = SETUP_LD;
                    edge_d   = '0;
                    frame_d  = '0;
                    target_d = long_frame_i ? EDGES_BYTES : EDGES_SHORT; // see R09 see R18
                end
            end
            adch_pkg::ADCH_LOW: begin
                if (abort_now) begin
                    state_d   = adch_pkg::ADCH_DESEL;
                    cs_n_d    = 1'b1;
                    aborted_d = 1'b1;
                    edge_d    = '0; // see R23
                    cnt_d     = conv_done ? CSW_LD : ACQ_LD; // see R11 see R12
                end else if (low_end) begin
                    // sample late in the low phase, well past clock-to-output delay
                    frame_d = frame_cap; // see R21 see R03
                    if (last_edge) begin
                        // all wanted bits are in before select rises
                        state_d = adch_pkg::ADCH_DESEL;
                        cs_n_d  = 1'b1; // see R10
                        edge_d  = '0; // see R23
                        cnt_d   = CSW_LD; // see R11
                        done_d  = 1'b1;
                    end else begin
                        state_d = adch_pkg::ADCH_HIGH;
                        sclk_d  = 1'b1; // see R13
                        edge_d  = edge_q + `ADCH_EDGE_W'(1); // see R23
                        cnt_d   = HALF_LD;
                    end
                end
            end
            adch_pkg::ADCH_HIGH: begin
                if (abort_now) begin
                    state_d   = adch_pkg::ADCH_DESEL;
                    cs_n_d    = 1'b1;
                    sclk_d    = 1'b0;
                    aborted_d = 1'b1;
                    edge_d    = '0; // see R23
                    cnt_d     = conv_done ? CSW_LD : ACQ_LD; // see R12
                end else if (high_end) begin
                    state_d = adch_pkg::ADCH_LOW;
                    sclk_d  = 1'b0; // see R13
                    cnt_d   = HALF_LD;
                end
            end
            adch_pkg::ADCH_DESEL: begin
                // select stays high for the deselect or acquisition wait
                if (cnt_zero) begin // see R11 see R12
                    state_d = adch_pkg::ADCH_IDLE;
                end
            end
            adch_pkg::ADCH_OFF: begin
                if (!power_down_i) begin
                    state_d = adch_pkg::ADCH_WAKE;
                    pwr_n_d = 1'b1; // see R17
                    cnt_d   = WAKE_LD; // see R15
                end
            end
            default: begin
                state_d = adch_pkg::ADCH_IDLE;
                cs_n_d  = 1'b1;
                sclk_d  = 1'b0;
            end
        endcase
    end

    // converter output is only meaningful with select low; sampled twice first
    always_ff @(posedge clk_sys_i) begin
        dout_meta_q <= dout_i; // see R07
        dout_sync_q <= dout_meta_q;
    end

    // control registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // reset stands in for first power: wait for the reference
            state_q <= adch_pkg::ADCH_WAKE;
            cnt_q   <= WAKE_LD; // see R14
            edge_q  <= '0;
            target_q <= EDGES_SHORT;
            sclk_q  <= 1'b0;
            cs_n_q  <= 1'b1;
            pwr_n_q <= 1'b1;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            edge_q   <= edge_d;
            target_q <= target_d;
            sclk_q   <= sclk_d;
            cs_n_q   <= cs_n_d;
            pwr_n_q  <= pwr_n_d;
        end
    end

    // result registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            frame_q     <= '0;
            done_q      <= 1'b0;
            aborted_q   <= 1'b0;
            ready_q     <= 1'b0;
            result_q    <= '0;
            sub_q       <= '0;
            frame_out_q <= '0;
        end else begin
            frame_q   <= frame_d;
            done_q    <= done_d;
            aborted_q <= aborted_d;
            ready_q   <= (state_d == adch_pkg::ADCH_IDLE) && !start_ok;
            if (done_d) begin
                // straight binary, msb at frame position twelve, lsb at three
                result_q    <= frame_d[`ADCH_RES_LSB +: `ADCH_RES_W]; // see R04 see R22
                // both sub-bits hold data in the long frame, only the upper one in the short frame
                sub_q       <= frame_d[`ADCH_SUB_LSB +: `ADCH_SUB_W]; // see R05 see R06
                // two bytes, three zeros and five msbs first
                frame_out_q <= frame_d; // see R19 see R20
            end
        end
    end

    assign sclk_o         = sclk_q;
    assign cs_n_o         = cs_n_q;
    assign power_down_n_o = pwr_n_q;
    assign ready_o        = ready_q;
    assign done_o         = done_q;
    assign aborted_o      = aborted_q;
    assign result_o       = result_q;
    assign sub_bits_o     = sub_q;
    assign frame_o        = frame_out_q;

endmodule

// ---- sim/adch_host_assertions.sv ----
// assertion checker for the converter readout host
`timescale 1ns/1ps
`include "adch_cfg.svh"
module adch_host_assertions #(
    parameter bit LOW_SUPPLY = 1'b0,
    parameter int WAKE_CYC   = 50
) (
    input wire logic                     clk_sys_i,
    input wire logic                     rst_i,
    input wire logic                     start_i,
    input wire logic                     long_frame_i,
    input wire logic                     abort_i,
    input wire logic                     power_down_i,
    input wire logic                     dout_i,
    input wire logic                     sclk_o,
    input wire logic                     cs_n_o,
    input wire logic                     power_down_n_o,
    input wire logic                     ready_o,
    input wire logic                     done_o,
    input wire logic                     aborted_o,
    input wire logic [`ADCH_RES_W-1:0]   result_o,
    input wire logic [`ADCH_SUB_W-1:0]   sub_bits_o,
    input wire logic [`ADCH_FRAME_W-1:0] frame_o
);
    localparam int HALF = LOW_SUPPLY ? 27 : 21;
    logic       sclk_q;
    logic       long_q;
    logic       sab_q;
    logic [4:0] rise_q;
    logic [7:0] hi_q;
    logic [7:0] csh_q;
    wire        take = start_i && ready_o && !power_down_i;
    // deselect count saturates so long idle spans never wrap below the limits
    always_ff @(posedge clk_sys_i) begin
        sclk_q <= rst_i ? 1'b0 : sclk_o;
        hi_q   <= (rst_i || !sclk_o) ? 8'h00 : hi_q + 8'h01;
        csh_q  <= (rst_i || !cs_n_o) ? 8'h00 : csh_q + {7'h00, csh_q != 8'hFF};
        rise_q <= (rst_i || cs_n_o) ? 5'h00 : rise_q + {4'h0, sclk_o & ~sclk_q};
        long_q <= take ? long_frame_i : long_q;
        sab_q  <= (rst_i || !cs_n_o) ? 1'b0 : (sab_q || (aborted_o && rise_q < 5'h0D));
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_start_sel_low: assert property (take |=> !cs_n_o)
        else $error("select did not fall after start");
    a_idle_sclk_low: assert property (cs_n_o |-> !sclk_o)
        else $error("serial clock high while deselected");
    a_sel_setup_low: assert property ($fell(cs_n_o) |-> !sclk_o [*8])
        else $error("serial clock rose too soon after select");
    a_sclk_high_width: assert property ($fell(sclk_o) && !aborted_o |-> hi_q == HALF)
        else $error("serial clock high phase wrong length");
    a_frame_edge_count: assert property (done_o |-> rise_q == (long_q ? 5'h10 : 5'h0D))
        else $error("wrong number of serial clock rises in frame");
    a_done_sel_high: assert property (done_o |-> cs_n_o && !sclk_o)
        else $error("select not raised at frame end");
    a_abort_sel_high: assert property (abort_i && !cs_n_o |=> cs_n_o && !sclk_o)
        else $error("abort did not raise select");
    a_deselect_time: assert property ($fell(cs_n_o) |-> csh_q >= 8'h19)
        else $error("deselect time too short");
    a_acq_time: assert property ($fell(cs_n_o) && sab_q |-> csh_q >= 8'h9D)
        else $error("restart too soon after abort");
    a_pd_pin_low: assert property (power_down_i && ready_o |=> !power_down_n_o)
        else $error("shutdown pin not lowered");
    a_off_no_frame: assert property (!power_down_n_o |-> cs_n_o && !ready_o)
        else $error("frame started in shutdown");
    a_wake_wait: assert property ($rose(power_down_n_o) |-> !ready_o [*8])
        else $error("ready too soon after wake");
    a_result_fields: assert property (done_o |-> result_o == frame_o[12:3])
        else $error("result does not match frame positions");
endmodule

bind adch_host adch_host_assertions #(.LOW_SUPPLY(LOW_SUPPLY), .WAKE_CYC(WAKE_CYC))
    adch_host_assertions_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
    .long_frame_i(long_frame_i), .abort_i(abort_i), .power_down_i(power_down_i),
    .dout_i(dout_i), .sclk_o(sclk_o), .cs_n_o(cs_n_o), .power_down_n_o(power_down_n_o),
    .ready_o(ready_o), .done_o(done_o), .aborted_o(aborted_o), .result_o(result_o),
    .sub_bits_o(sub_bits_o), .frame_o(frame_o));

// ---- sim/adch_conv_model.sv ----
// behavioural model of the serial converter at the far end of the link
`timescale 1ns/1ps
module adch_conv_model (
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       power_down_n_i,
    input  wire logic [9:0] value_i,
    input  wire logic [1:0] sub_i,
    output logic            dout_o
);
    logic [15:0] held;
    int          edges;
    initial dout_o = 1'b0;
    always @(negedge cs_n_i) begin
        edges = 0;
        // reference is off in shutdown, so a code taken then is garbage
        held = power_down_n_i ? {3'h0, value_i, sub_i, 1'b0} : 16'hFFFF;
        dout_o = 1'b0;
    end
    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            edges = edges + 1;
            #20 dout_o = (edges < 16) ? held[15 - edges] : 1'b0;
        end
    end
    // no pull on the pin: a released line shows the opposite level
    always @(posedge cs_n_i) #13 dout_o = ~dout_o;
endmodule

// ---- sim/adch_host_test.sv ----
// self-checking bench for the converter readout host
`timescale 1ns/1ps
module adch_host_test;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        start_i = 1'b0;
    logic        long_frame_i = 1'b0;
    logic        abort_i = 1'b0;
    logic        power_down_i = 1'b0;
    logic        dout_i;
    logic        sclk_o, cs_n_o, power_down_n_o, ready_o, done_o, aborted_o;
    logic [9:0]  result_o;
    logic [1:0]  sub_bits_o;
    logic [15:0] frame_o;
    logic [9:0]  value = 10'h000;
    logic [1:0]  subv = 2'h0;
    int          mismatches = 0;
    int          samples_checked = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    adch_host #(.WAKE_CYC(50)) adch_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .start_i(start_i), .long_frame_i(long_frame_i), .abort_i(abort_i),
        .power_down_i(power_down_i), .dout_i(dout_i), .sclk_o(sclk_o), .cs_n_o(cs_n_o),
        .power_down_n_o(power_down_n_o), .ready_o(ready_o), .done_o(done_o),
        .aborted_o(aborted_o), .result_o(result_o), .sub_bits_o(sub_bits_o), .frame_o(frame_o));
    adch_conv_model adch_conv_model_inst (.sclk_i(sclk_o), .cs_n_i(cs_n_o),
        .power_down_n_i(power_down_n_o), .value_i(value), .sub_i(subv), .dout_o(dout_i));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_on(input int sel, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < 4000 && !hit; i++) begin
            @(negedge clk_sys_i);
            hit = (sel == 0) ? ready_o === 1'b1 : (sel == 1) ? done_o === 1'b1 : aborted_o === 1'b1;
        end
        chk("handshake", 16'h0001, {15'h0, hit});
    endtask
    task automatic run_frame(input logic lng, input logic [9:0] v, input logic [1:0] s);
        bit          hit;
        logic [15:0] ef;
        ef = lng ? {3'h0, v, s, 1'b0} : {3'h0, v, s[1], 2'h0};
        value = v;
        subv = s;
        wait_on(0, hit);
        long_frame_i = lng;
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
        wait_on(1, hit);
        chk("frame", ef, frame_o);
        chk("result", {6'h00, v}, {6'h00, result_o});
        chk("sub bits", {14'h0, ef[2:1]}, {14'h0, sub_bits_o});
    endtask
    task automatic t_long;
        run_frame(1'b1, 10'h3FF, 2'h3);
        run_frame(1'b1, 10'h201, 2'h1);
        $display("long frames finished");
    endtask
    task automatic t_short;
        run_frame(1'b0, 10'h155, 2'h2);
        run_frame(1'b0, 10'h2AA, 2'h1);
        $display("short frames finished");
    endtask
    task automatic t_abort;
        bit hit;
        wait_on(0, hit);
        value = 10'h0F0;
        long_frame_i = 1'b1;
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
        // a few serial clocks into the frame, well before the thirteenth rise
        repeat (200) @(negedge clk_sys_i);
        abort_i = 1'b1;
        wait_on(2, hit);
        abort_i = 1'b0;
        chk("select", 16'h0001, {15'h0, cs_n_o});
        chk("kept result", 16'h02AA, {6'h00, result_o});
        run_frame(1'b1, 10'h0F0, 2'h0);
        $display("abort finished");
    endtask
    task automatic t_power;
        bit hit;
        wait_on(0, hit);
        power_down_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk("shutdown pin", 16'h0000, {15'h0, power_down_n_o});
        start_i = 1'b1;
        repeat (30) @(negedge clk_sys_i);
        chk("select in shutdown", 16'h0001, {15'h0, cs_n_o});
        start_i = 1'b0;
        power_down_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk("wake pin", 16'h0001, {15'h0, power_down_n_o});
        run_frame(1'b1, 10'h07C, 2'h2);
        $display("power down finished");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_long();
        t_short();
        t_abort();
        t_power();
        finish_test();
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule
